// >>> ssbp_regs.vh
`ifndef SSBP_REGS_VH
`define SSBP_REGS_VH

// ****************************************************************
// register map
// ****************************************************************
`define SSBP_OFS_CTRL       12'h000
`define SSBP_OFS_STATUS     12'h004
`define SSBP_OFS_CAPTURE    12'h008

// ****************************************************************
// control fields
// ****************************************************************
`define SSBP_CTRL_CAP_EN    0
`define SSBP_CTRL_OVF_CLR   1
`define SSBP_CTRL_RST       1'h0

// ****************************************************************
// status fields
// ****************************************************************
`define SSBP_ST_BURST       0
`define SSBP_ST_XFER        1
`define SSBP_ST_XFER_WR     2
`define SSBP_ST_OVF         3
`define SSBP_ST_CNT_LSB     4
`define SSBP_ST_CNT_MSB     8

// ****************************************************************
// memory geometry
// ****************************************************************
`define SSBP_AW             17
`define SSBP_DW             36
`define SSBP_LANES          4
`define SSBP_LANE_W         9
`define SSBP_WORDS          131072
`define SSBP_FIFO_DEPTH     16
`define SSBP_FIFO_AW        4

`endif

// >>> ssbp_port.v
// How it works
// - burst order select high: low address bits are start XOR count.
// - burst order select low: low address bits are start plus count.
// - the two-bit count wraps after the fourth word and keeps going.
// - the data of a load sampled at cycle n moves during cycle n+1.
// - inputs other than output enable and reset are taken at the rising edge; read data follows that edge.
// - each advance after a read load drives the next word a cycle on.
// - a load in the cycle of the fourth word starts with no idle cycle.
// - an early load ends the burst after its pending transfer is done.
// - a deselect ends a burst after its pending transfer; advances idle.
// - with hold off, an access is taken every cycle, in any direction.
// - advances ignore the write control; the load fixes the direction.
// - an edge with the clock hold high changes no port pipeline register or bus state; the APB registers still update.
// - select needs both low selects low and the high select high.
// - each of four low-active byte lane writes gates one 9-bit lane.
//
// The address map and the APB register port were chosen for this implementation.
`default_nettype none
`include "ssbp_regs.vh"

// ****************************************************************
// capture fifo
// ****************************************************************
module ssbp_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_r[rp_q];
    assign count     = cnt_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_r[wp_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ****************************************************************
// sram port top
// ****************************************************************
module ssbp_port (
    input  wire                       CLOCK,
    input  wire                       RST_N,
    input  wire [`SSBP_AW-1:0]        ADDR,
    input  wire                       WRITE_N,
    input  wire                       ADVANCE_OR_LOAD,
    input  wire                       CHIP_SELECT_A_N,
    input  wire                       CHIP_SELECT_B,
    input  wire                       CHIP_SELECT_C_N,
    input  wire                       CLOCK_HOLD_N,
    input  wire [`SSBP_LANES-1:0]     BYTE_LANE_WRITE_N,
    input  wire                       BURST_ORDER_SELECT,
    input  wire                       OUTPUT_ENABLE_N,
    input  wire [`SSBP_DW-1:0]        DQ_IN,
    output reg  [`SSBP_DW-1:0]        DQ_OUT,
    output wire                       DQ_OE,
    output reg                        CAPTURE_READY,
    input  wire                       PSEL,
    input  wire                       PENABLE,
    input  wire                       PWRITE,
    input  wire [11:0]                PADDR,
    input  wire [31:0]                PWDATA,
    output reg  [31:0]                PRDATA,
    output reg                        PREADY,
    output reg                        PSLVERR
);
    // ************************************************************
    // reset release
    // ************************************************************
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n_i = rst_s2_q;

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ************************************************************
    // access pipeline
    // ************************************************************
    reg  [`SSBP_DW-1:0]    mem_r [0:`SSBP_WORDS-1];
    reg  [`SSBP_AW-1:0]    base_q;
    reg  [1:0]             cnt_q;
    reg                    burst_q;
    reg                    burst_wr_q;
    reg                    xfer_q;
    reg                    xfer_wr_q;
    reg  [`SSBP_AW-1:0]    xfer_addr_q;
    reg  [`SSBP_LANES-1:0] xfer_bw_n_q;
    reg                    drive_q;
    reg                    cap_en_q;
    reg                    ovf_q;

    wire                   run = ~CLOCK_HOLD_N;
    wire                   sel = ~CHIP_SELECT_A_N & CHIP_SELECT_B
                                 & ~CHIP_SELECT_C_N;
    wire                   load = ~ADVANCE_OR_LOAD & sel;
    wire                   adv  = ADVANCE_OR_LOAD & burst_q;
    wire [1:0]             cnt_n = cnt_q + 2'h1;
    reg  [1:0]             low_n;
    reg                    nx_xfer;
    reg                    nx_wr;
    reg  [`SSBP_AW-1:0]    nx_addr;
    reg  [`SSBP_DW-1:0]    wr_word;
    reg  [`SSBP_DW-1:0]    rd_word;
    wire                   do_write = run & xfer_q & xfer_wr_q;
    integer                i;

    always @* begin
        if (BURST_ORDER_SELECT) begin
            low_n = base_q[1:0] ^ cnt_n;
        end else begin
            low_n = base_q[1:0] + cnt_n;
        end
        nx_xfer = 1'b0;
        nx_wr   = 1'b0;
        nx_addr = xfer_addr_q;
        if (load) begin
            nx_xfer = 1'b1;
            nx_wr   = ~WRITE_N;
            nx_addr = ADDR;
        end else if (adv) begin
            nx_xfer = 1'b1;
            nx_wr   = burst_wr_q;
            nx_addr = {base_q[`SSBP_AW-1:2], low_n};
        end
    end

    always @* begin
        wr_word = mem_r[xfer_addr_q];
        for (i = 0; i < `SSBP_LANES; i = i + 1) begin
            if (!xfer_bw_n_q[i]) begin
                wr_word[i*`SSBP_LANE_W +: `SSBP_LANE_W] =
                    DQ_IN[i*`SSBP_LANE_W +: `SSBP_LANE_W];
            end
        end
        if (do_write && xfer_addr_q == nx_addr) begin
            rd_word = wr_word;
        end else begin
            rd_word = mem_r[nx_addr];
        end
    end

    always @(posedge CLOCK) begin
        if (do_write) begin
            mem_r[xfer_addr_q] <= wr_word;
        end
    end

    always @(posedge CLOCK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            base_q      <= {`SSBP_AW{1'b0}};
            cnt_q       <= 2'h0;
            burst_q     <= 1'b0;
            burst_wr_q  <= 1'b0;
            xfer_q      <= 1'b0;
            xfer_wr_q   <= 1'b0;
            xfer_addr_q <= {`SSBP_AW{1'b0}};
            xfer_bw_n_q <= {`SSBP_LANES{1'b1}};
            drive_q     <= 1'b0;
            DQ_OUT      <= {`SSBP_DW{1'b0}};
        end else if (run) begin
            if (!ADVANCE_OR_LOAD) begin
                burst_q    <= sel;
                burst_wr_q <= ~WRITE_N;
                base_q     <= ADDR;
                cnt_q      <= 2'h0;
            end else if (burst_q) begin
                cnt_q <= cnt_n;
            end
            xfer_q      <= nx_xfer;
            xfer_wr_q   <= nx_wr;
            xfer_addr_q <= nx_addr;
            xfer_bw_n_q <= BYTE_LANE_WRITE_N;
            drive_q     <= nx_xfer & ~nx_wr;
            if (nx_xfer & ~nx_wr) begin
                DQ_OUT <= rd_word;
            end
        end
    end

    // output enable pin floats the bus without waiting for an edge
    assign DQ_OE = drive_q & ~OUTPUT_ENABLE_N;

    // ************************************************************
    // write capture and apb registers
    // ************************************************************
    wire                     fifo_ready;
    wire                     fifo_valid;
    wire [`SSBP_DW-1:0]      fifo_data;
    wire [`SSBP_FIFO_AW:0]   fifo_cnt;
    wire                     cap_push = do_write & cap_en_q;
    wire                     apb_done = PSEL & PENABLE & PREADY;
    wire                     pop = apb_done & ~PWRITE
                                   & (PADDR == `SSBP_OFS_CAPTURE);
    wire                     ctrl_wr = apb_done & PWRITE
                                       & (PADDR == `SSBP_OFS_CTRL);
    reg  [31:0]              rdata;
    reg                      hit;

    ssbp_fifo #(
        .WIDTH (`SSBP_DW),
        .DEPTH (`SSBP_FIFO_DEPTH),
        .AW    (`SSBP_FIFO_AW)
    ) u_fifo (
        .clk       (CLOCK),
        .rst_n     (rst_n_i),
        .in_valid  (cap_push),
        .in_ready  (fifo_ready),
        .in_data   (wr_word),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .out_data  (fifo_data),
        .count     (fifo_cnt)
    );

    always @* begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (PADDR)
            `SSBP_OFS_CTRL: begin
                rdata[`SSBP_CTRL_CAP_EN] = cap_en_q;
            end
            `SSBP_OFS_STATUS: begin
                rdata[`SSBP_ST_BURST]   = burst_q;
                rdata[`SSBP_ST_XFER]    = xfer_q;
                rdata[`SSBP_ST_XFER_WR] = xfer_wr_q;
                rdata[`SSBP_ST_OVF]     = ovf_q;
                rdata[`SSBP_ST_CNT_MSB:`SSBP_ST_CNT_LSB] = fifo_cnt;
            end
            `SSBP_OFS_CAPTURE: begin
                if (fifo_valid) begin
                    rdata = fifo_data[31:0];
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always @(posedge CLOCK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            PREADY        <= 1'b0;
            PRDATA        <= 32'h0000_0000;
            PSLVERR       <= 1'b0;
            cap_en_q      <= `SSBP_CTRL_RST;
            ovf_q         <= 1'b0;
            CAPTURE_READY <= 1'b0;
        end else begin
            PREADY        <= PSEL & ~PENABLE;
            CAPTURE_READY <= fifo_ready;
            if (PSEL & ~PENABLE) begin
                PRDATA  <= PWRITE ? 32'h0000_0000 : rdata;
                PSLVERR <= ~hit;
            end
            if (ctrl_wr) begin
                cap_en_q <= PWDATA[`SSBP_CTRL_CAP_EN];
            end
            // a lost capture in the clearing cycle still sets the flag
            if (cap_push & ~fifo_ready) begin
                ovf_q <= 1'b1;
            end else if (ctrl_wr & PWDATA[`SSBP_CTRL_OVF_CLR]) begin
                ovf_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> ssbp_port_props.sv
`default_nettype none
`include "ssbp_regs.vh"
module ssbp_port_props (
    input wire logic                CLOCK,
    input wire logic                RST_N,
    input wire logic                WRITE_N,
    input wire logic                ADVANCE_OR_LOAD,
    input wire logic                CHIP_SELECT_A_N,
    input wire logic                CHIP_SELECT_B,
    input wire logic                CHIP_SELECT_C_N,
    input wire logic                CLOCK_HOLD_N,
    input wire logic                OUTPUT_ENABLE_N,
    input wire logic [`SSBP_DW-1:0] DQ_OUT,
    input wire logic                DQ_OE,
    input wire logic                PSEL,
    input wire logic                PENABLE,
    input wire logic                PREADY
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // port cycle kinds
    // ****************************************************************
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    wire logic chip_sel = !CHIP_SELECT_A_N && CHIP_SELECT_B
                          && !CHIP_SELECT_C_N;
    sequence s_load_rd;
        !CLOCK_HOLD_N && !ADVANCE_OR_LOAD && chip_sel && WRITE_N;
    endsequence
    sequence s_load_wr;
        !CLOCK_HOLD_N && !ADVANCE_OR_LOAD && chip_sel && !WRITE_N;
    endsequence
    sequence s_desel;
        !CLOCK_HOLD_N && !ADVANCE_OR_LOAD && !chip_sel;
    endsequence
    sequence s_adv;
        !CLOCK_HOLD_N && ADVANCE_OR_LOAD;
    endsequence
    a_rd_drives_next: assert property (
        s_load_rd ##1 !OUTPUT_ENABLE_N |-> DQ_OE)
        else $error("read data cycle not driven");
    a_burst_rd_drives: assert property (
        s_load_rd ##1 s_adv ##1 !OUTPUT_ENABLE_N |-> DQ_OE)
        else $error("burst read word not driven");
    a_adv_ignores_dir: assert property (
        s_load_wr ##1 (s_adv and WRITE_N) |=> !DQ_OE)
        else $error("advance took direction from write control");
    a_wr_cycle_float: assert property (
        s_load_wr |=> !DQ_OE)
        else $error("bus driven in write data cycle");
    a_desel_float: assert property (
        s_desel |=> !DQ_OE)
        else $error("bus driven after deselect");
    a_idle_float: assert property (
        s_desel ##1 s_adv[*2] |=> !DQ_OE)
        else $error("bus driven in idle cycle");
    a_hold_freezes: assert property (
        CLOCK_HOLD_N |=> $stable(DQ_OUT))
        else $error("read data changed on a held edge");
    a_oe_floats: assert property (
        OUTPUT_ENABLE_N |-> !DQ_OE)
        else $error("bus driven with output enable off");
    a_apb_ready_once: assert property (
        PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("apb ready not a single access cycle");
endmodule
bind ssbp_port ssbp_port_props u_props (.CLOCK(CLOCK), .RST_N(RST_N),
    .WRITE_N(WRITE_N), .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD),
    .CHIP_SELECT_A_N(CHIP_SELECT_A_N), .CHIP_SELECT_B(CHIP_SELECT_B),
    .CHIP_SELECT_C_N(CHIP_SELECT_C_N), .CLOCK_HOLD_N(CLOCK_HOLD_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY));
`default_nettype wire

// >>> ssbp_ctl_model.sv
`default_nettype none
module ssbp_ctl_model (
    input  wire logic        clock,
    output var  logic [16:0] addr,
    output var  logic        write_n,
    output var  logic        advance_or_load,
    output var  logic        cs_a_n,
    output var  logic        cs_b,
    output var  logic        cs_c_n,
    output var  logic        clock_hold_n,
    output var  logic [3:0]  byte_lane_write_n,
    output var  logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // controller side of the port, one cycle per call
    // ****************************************************************
    initial begin
        {addr, write_n, advance_or_load, cs_a_n, cs_b, cs_c_n} = {17'h0, 5'h1D};
        clock_hold_n = 1'b0;
        byte_lane_write_n = 4'hF;
        dq_in = 36'h0;
    end
    task automatic step(input logic hold, ld, wr_n, sel,
                        input logic [16:0] a, input logic [3:0] be,
                        input logic [35:0] d, input logic dv);
        logic [1:0] pick;
        pick = 2'($urandom % 3);
        @(posedge clock);
        clock_hold_n <= hold;
        advance_or_load <= !ld;
        addr <= ld ? a : 17'($urandom);
        write_n <= wr_n;
        byte_lane_write_n <= be;
        // one select false at random when deselecting
        cs_a_n <= !sel && pick == 2'h0;
        cs_b <= sel || pick != 2'h1;
        cs_c_n <= !sel && pick == 2'h2;
        // data only in the write data cycle, a moving pattern otherwise
        dq_in <= dv ? d : ~dq_in;
    endtask
endmodule
`default_nettype wire

// >>> sync_sram_burst_port_tb.sv
`default_nettype none
`include "ssbp_regs.vh"
module sync_sram_burst_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, ordr, oe_n, psel, pen, pwr, pready, pslverr, err;
    logic wr_n, adv, cs_a_n, cs_b, cs_c_n, clk_hold_n, dq_oe, cap_rdy, hold_s;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [16:0] addr, a, b_a, p_a;
    logic [3:0]  be_n, p_be;
    logic [`SSBP_DW-1:0] dq_in, dq_out, mem [int], expq [$];
    logic [31:0] capq [$];
    logic [1:0]  k = 2'h0;
    logic        open = 1'b0, dir_rd, p_v = 1'b0, p_rd, cap_en = 1'b0;
    int          n_errors = 0, checks_done = 0, cyc_n = 0;
    ssbp_ctl_model u_ctl (.clock(clk), .addr(addr), .write_n(wr_n),
        .advance_or_load(adv), .cs_a_n(cs_a_n), .cs_b(cs_b), .cs_c_n(cs_c_n),
        .clock_hold_n(clk_hold_n), .byte_lane_write_n(be_n), .dq_in(dq_in));
    ssbp_port u_dut (.CLOCK(clk), .RST_N(rst_n), .ADDR(addr), .WRITE_N(wr_n),
        .ADVANCE_OR_LOAD(adv), .CHIP_SELECT_A_N(cs_a_n), .CHIP_SELECT_B(cs_b),
        .CHIP_SELECT_C_N(cs_c_n), .CLOCK_HOLD_N(clk_hold_n),
        .BYTE_LANE_WRITE_N(be_n), .BURST_ORDER_SELECT(ordr),
        .OUTPUT_ENABLE_N(oe_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
        .CAPTURE_READY(cap_rdy), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));
    // ****************************************************************
    // clock, checks, cycle model and bus tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp_dq(input logic [35:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] got, exp);
        cmp_dq({4'h0, got}, {4'h0, exp});
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n > 5000) begin
            n_errors++;
            stop_test();
        end
    end
    // read words leave the queue only on edges that were not held
    always @(posedge clk) begin
        hold_s = clk_hold_n;
        #1;
        if (!hold_s && dq_oe === 1'b1)
            cmp_dq(dq_out, expq.size() ? expq.pop_front() : 'x);
    end
    task automatic cyc(input logic ld, w_n, sel, input logic [16:0] ad,
                       input logic [3:0] be);
        logic [35:0] d;
        logic dv;
        d = {4'($urandom), 32'($urandom)};
        dv = p_v && !p_rd;
        if (dv) begin
            for (int i = 0; i < 4; i++)
                if (!p_be[i]) mem[p_a][9*i+:9] = d[9*i+:9];
            if (cap_en && capq.size() < 16) capq.push_back(d[31:0]);
        end
        p_v = 1'b0;
        if (ld && !sel) open = 1'b0;
        else if (ld) begin
            b_a = ad;
            k = 2'h0;
            open = 1'b1;
            dir_rd = w_n;
        end
        else k = k + 2'h1;
        if (open) begin
            p_a = {b_a[16:2],
                   ordr ? b_a[1:0] ^ k : b_a[1:0] + k};
            p_v = 1'b1;
            p_rd = dir_rd;
            p_be = be;
            if (p_rd) expq.push_back(mem[p_a]);
        end
        u_ctl.step(1'b0, ld, w_n, sel, ad, be, d, dv);
    endtask
    task automatic hold_for(input int n);
        repeat (n) u_ctl.step(1'b1, 1'b1, 1'($urandom), 1'b1, 17'($urandom),
                              4'h0, 36'h0, 1'b0);
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'h0;
    endtask
    initial begin
        {rst_n, ordr, oe_n, psel, pen, pwr, paddr, pwdata} = '0;
        void'($urandom(32'h9CFCDE4F));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int o = 0; o < 2; o++) begin
            ordr <= o[0];
            a = 17'($urandom);
            cyc(1'b1, 1'b0, 1'b1, a, 4'h0);
            repeat (3) cyc(1'b0, 1'b1, 1'b1, 17'h0, 4'h0);
            cyc(1'b1, 1'b1, 1'b1, a, 4'h0);
            repeat (5) cyc(1'b0, 1'b0, 1'b1, 17'h0, 4'h0);
            cyc(1'b1, 1'b0, 1'b1, a ^ 17'h1, 4'hA);
            cyc(1'b1, 1'b1, 1'b1, a ^ 17'h1, 4'h0);
            cyc(1'b1, 1'b0, 1'b0, 17'h0, 4'h0);
            repeat (2) cyc(1'b0, 1'b1, 1'b1, 17'h0, 4'h0);
        end
        a = 17'($urandom);
        cyc(1'b1, 1'b0, 1'b1, a, 4'h0);
        hold_for(2);
        cyc(1'b1, 1'b1, 1'b1, a, 4'h0);
        hold_for(2);
        cyc(1'b1, 1'b1, 1'b1, a, 4'h0);
        oe_n <= 1'b1;
        #2;
        cmp_reg({31'h0, dq_oe}, 32'h0);
        void'(expq.pop_front());
        cyc(1'b1, 1'b0, 1'b0, 17'h0, 4'h0);
        #2;
        cmp_reg({31'h0, dq_oe}, 32'h0);
        cyc(1'b0, 1'b1, 1'b1, 17'h0, 4'h0);
        oe_n <= 1'b0;
        apb(1'b1, `SSBP_OFS_CTRL, 32'h1);
        apb(1'b0, `SSBP_OFS_CTRL, 32'h0);
        cmp_reg(rd, 32'h1);
        cap_en = 1'b1;
        for (int i = 0; i < 17; i++) cyc(1'b1, 1'b0, 1'b1, 17'(i), 4'h0);
        cyc(1'b1, 1'b0, 1'b0, 17'h0, 4'h0);
        cyc(1'b0, 1'b1, 1'b1, 17'h0, 4'h0);
        cap_en = 1'b0;
        #1;
        cmp_reg({31'h0, cap_rdy}, 32'h0);
        apb(1'b0, `SSBP_OFS_STATUS, 32'h0);
        cmp_reg({23'h0, rd[8:0]}, 32'h108);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, `SSBP_OFS_CAPTURE, 32'h0);
            cmp_reg(rd, capq.pop_front());
        end
        apb(1'b1, `SSBP_OFS_CTRL, 32'h2);
        apb(1'b0, `SSBP_OFS_STATUS, 32'h0);
        cmp_reg({23'h0, rd[8:0]}, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        cmp_reg({err, rd[30:0]}, 32'h80000000);
        cmp_reg(32'(expq.size()), 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
